// >>> aer_err_src.sv
// Error detector stand-in that pulses event lines for one cycle
module aer_err_src (
  input  wire logic         clk_in,
  output logic      [31:0]  unc_err_out,
  output logic      [127:0] unc_hdr_out,
  output logic      [31:0]  cor_err_out,
  output logic      [31:0]  sec_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    unc_err_out = 32'h0;
    unc_hdr_out = 128'h0;
    cor_err_out = 32'h0;
    sec_err_out = 32'h0;
  end
  task fire(input logic [31:0] u, input logic [127:0] h, input logic [31:0] c, s);
    @(posedge clk_in);
    unc_err_out <= u;
    unc_hdr_out <= h;
    cor_err_out <= c;
    sec_err_out <= s;
    @(posedge clk_in);
    unc_err_out <= 32'h0;
    // Header is only meaningful with the event, so scramble it afterwards
    unc_hdr_out <= ~h;
    cor_err_out <= 32'h0;
    sec_err_out <= 32'h0;
  endtask
endmodule

// >>> aer_hdr_log.v
// Sixteen-byte header log, four words with registered read data
module aer_hdr_log (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire         load_in,
  input  wire [127:0] hdr_in,
  input  wire [1:0]   rd_idx_in,
  output reg  [31:0]  rd_data_out
);
  reg [31:0] mem_q [0:3];
  genvar g;
  // Byte 0 of the header arrives in hdr_in[127:120]; each word keeps its lowest byte on top
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_word
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          mem_q[g] <= 32'h00000000;
        end else if (load_in) begin
          mem_q[g] <= hdr_in[127-32*g -: 32]; // R7
        end
      end
    end
  endgenerate
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= 32'h00000000;
    end else begin
      rd_data_out <= mem_q[rd_idx_in];
    end
  end
endmodule

// >>> aer_regs.vh
// Register offsets, field layouts and reset values of the error reporting bank
`ifndef AER_REGS_VH
`define AER_REGS_VH
`define AER_OFS_UNC_STATUS 12'h104
`define AER_OFS_UNC_MASK   12'h108
`define AER_OFS_UNC_SEV    12'h10C
`define AER_OFS_COR_STATUS 12'h110
`define AER_OFS_COR_MASK   12'h114
`define AER_OFS_CAP_CTRL   12'h118
`define AER_OFS_HDR_LOG0   12'h11C
`define AER_OFS_HDR_LOG1   12'h120
`define AER_OFS_HDR_LOG2   12'h124
`define AER_OFS_HDR_LOG3   12'h128
`define AER_OFS_SEC_STATUS 12'h12C
`define AER_OFS_IRQ_STATUS 12'h140
`define AER_OFS_IRQ_MASK   12'h144
`define AER_UNC_VALID      32'h001FF011
`define AER_UNC_SEV_RESET  32'h00062011
`define AER_COR_VALID      32'h000011C1
`define AER_SEC_VALID      32'h00003FEF
`define AER_CAP_GEN_CAP    5
`define AER_CAP_GEN_EN     6
`define AER_CAP_CHK_CAP    7
`define AER_CAP_CHK_EN     8
`define AER_IRQ_UNC        0
`define AER_IRQ_COR        1
`define AER_IRQ_SEC        2
`define AER_IRQ_VALID      3'h7
`endif

// >>> aer_regs_chk.sv
// Port-level timing and layout checks for the error reporting bank
`include "aer_regs.vh"
module aer_regs_chk (
  input logic        clk_in,
  input logic        nrst_in,
  input logic        wb_cyc_in,
  input logic        wb_stb_in,
  input logic        wb_we_in,
  input logic [11:0] wb_adr_in,
  input logic [31:0] wb_dat_out,
  input logic        wb_ack_out,
  input logic [31:0] unc_err_in,
  input logic [31:0] cor_err_in,
  input logic [31:0] sec_err_in,
  input logic        ecrc_gen_en_out,
  input logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire rd = wb_ack_out && !wb_we_in;
  // Any event or access may lead to an interrupt a few cycles later
  wire act = wb_ack_out || (|unc_err_in) || (|cor_err_in) || (|sec_err_in);
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
  AST_ACK_LAT: assert property ($rose(wb_cyc_in && wb_stb_in) |-> !wb_ack_out ##[1:2] wb_ack_out)
    else $error("ack latency");
  AST_ACK_REQ: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in) else $error("stray ack");
  AST_WR_ZERO: assert property (wb_ack_out && wb_we_in |-> wb_dat_out == 32'h0)
    else $error("write data nonzero");
  AST_UNC_RSV: assert property (rd && wb_adr_in == 12'h104 |-> (wb_dat_out & 32'hFFE00FEE) == 0)
    else $error("unc reserved set");
  AST_COR_RSV: assert property (rd && wb_adr_in == 12'h110 |-> (wb_dat_out & 32'hFFFFEE3E) == 0)
    else $error("cor reserved set");
  AST_SEC_RSV: assert property (rd && wb_adr_in == 12'h12C |-> (wb_dat_out & 32'hFFFFC010) == 0)
    else $error("sec reserved set");
  AST_CAP_RO: assert property (rd && wb_adr_in == 12'h118 |-> wb_dat_out[5] && wb_dat_out[7]
    && wb_dat_out[31:9] == 0) else $error("cap bits wrong");
  AST_ECRC_SRC: assert property ($changed(ecrc_gen_en_out) |-> wb_ack_out && wb_we_in
    && wb_adr_in == `AER_OFS_CAP_CTRL) else $error("enable moved alone");
  AST_IRQ_SRC: assert property ($rose(irq_out) |-> $past(act) || $past(act, 2) || $past(act, 3)
    || $past(act, 4)) else $error("irq without cause");
endmodule

// >>> aer_regs_top.v
// Error reporting register bank with a classic Wishbone slave and an interrupt
//
// Overview of operation
// R1: Uncorrectable status has sticky W1C flags at bits 0, 4, 12..20.
// R2: Uncorrectable mask is RW, one bit per status flag, resets zero.
// R3: Severity RW; bits 0,4,13,17,18 reset one, others zero.
// R4: Correctable status has sticky W1C flags at bits 0, 6, 7, 8, 12.
// R5: Correctable mask is RW at the same bits, resetting zero.
// R6: First error pointer RO in 4:0; bits 5, 7 read one; enables 6, 8.
// R7: Four header log words, lowest byte in bits 31:24, reset zero.
// R8: Secondary status has W1C flags at bits 0..3 and 5..13.
// R9: Secondary bits flag aborts, parity and system error assertions.
// R10: Flags set on any detected error, whatever the mask says.
// R11: First unmasked uncorrectable error loads pointer and header log.
//
// Local design decision: the Wishbone interface to the registers.
`include "aer_regs.vh"
module aer_regs_top (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire         wb_cyc_in,
  input  wire         wb_stb_in,
  input  wire         wb_we_in,
  input  wire [11:0]  wb_adr_in,
  input  wire [3:0]   wb_sel_in,
  input  wire [31:0]  wb_dat_in,
  output reg  [31:0]  wb_dat_out,
  output reg          wb_ack_out,
  input  wire [31:0]  unc_err_in,
  input  wire [127:0] unc_hdr_in,
  input  wire [31:0]  cor_err_in,
  input  wire [31:0]  sec_err_in,
  output reg          ecrc_gen_en_out,
  output reg          ecrc_chk_en_out,
  output reg          irq_out
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire        req;
  wire        wr_acc;
  wire [31:0] bmask;
  reg         phase_q;
  assign req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // Writes take effect in the ack cycle, once per access
  assign wr_acc = req & phase_q & wb_we_in;
  assign bmask  = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  function hit;
    input [11:0] adr;
    input [11:0] ofs;
    begin
      hit = (adr[11:2] == ofs[11:2]);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [31:0] msk;
    begin
      merge = (old & ~msk) | (dat & msk);
    end
  endfunction

  function [31:0] cap_word;
    input [4:0] ptr;
    input       gen;
    input       chk;
    begin
      cap_word                   = 32'h00000000;
      cap_word[4:0]              = ptr;
      cap_word[`AER_CAP_GEN_CAP] = 1'b1;
      cap_word[`AER_CAP_GEN_EN]  = gen;
      cap_word[`AER_CAP_CHK_CAP] = 1'b1;
      cap_word[`AER_CAP_CHK_EN]  = chk;
    end
  endfunction

  // ------------------------------------------------------------
  // Error inputs from the detectors, same clock domain
  // ------------------------------------------------------------
  wire [31:0] unc_set;
  wire [31:0] cor_set;
  wire [31:0] sec_set;
  assign unc_set = unc_err_in & `AER_UNC_VALID; // R10
  assign cor_set = cor_err_in & `AER_COR_VALID; // R10
  assign sec_set = sec_err_in & `AER_SEC_VALID; // R9

  // ------------------------------------------------------------
  // Write strobes, one per writable register, high only in the cycle before the ack
  // ------------------------------------------------------------
  wire wr_unc_st;
  wire wr_unc_mask;
  wire wr_unc_sev;
  wire wr_cor_st;
  wire wr_cor_mask;
  wire wr_cap_ctrl;
  wire wr_sec_st;
  wire wr_irq_st;
  wire wr_irq_mask;
  assign wr_unc_st   = wr_acc & hit(wb_adr_in, `AER_OFS_UNC_STATUS);
  assign wr_unc_mask = wr_acc & hit(wb_adr_in, `AER_OFS_UNC_MASK);
  assign wr_unc_sev  = wr_acc & hit(wb_adr_in, `AER_OFS_UNC_SEV);
  assign wr_cor_st   = wr_acc & hit(wb_adr_in, `AER_OFS_COR_STATUS);
  assign wr_cor_mask = wr_acc & hit(wb_adr_in, `AER_OFS_COR_MASK);
  assign wr_cap_ctrl = wr_acc & hit(wb_adr_in, `AER_OFS_CAP_CTRL);
  assign wr_sec_st   = wr_acc & hit(wb_adr_in, `AER_OFS_SEC_STATUS);
  assign wr_irq_st   = wr_acc & hit(wb_adr_in, `AER_OFS_IRQ_STATUS);
  assign wr_irq_mask = wr_acc & hit(wb_adr_in, `AER_OFS_IRQ_MASK);

  // ------------------------------------------------------------
  // Status registers
  // ------------------------------------------------------------
  wire [31:0] unc_status;
  wire [31:0] cor_status;
  wire [31:0] sec_status;
  wire [31:0] unc_clr;
  wire [31:0] cor_clr;
  wire [31:0] sec_clr;
  // Clears honour the byte lanes, so a narrow write leaves other flags alone
  assign unc_clr = wr_unc_st ? (wb_dat_in & bmask) : 32'h00000000;
  assign cor_clr = wr_cor_st ? (wb_dat_in & bmask) : 32'h00000000;
  assign sec_clr = wr_sec_st ? (wb_dat_in & bmask) : 32'h00000000;

  aer_w1c_reg #(.VALID(`AER_UNC_VALID)) u_unc_status ( // R1
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .set_in  (unc_set),
    .clr_in  (unc_clr),
    .q_out   (unc_status)
  );
  aer_w1c_reg #(.VALID(`AER_COR_VALID)) u_cor_status ( // R4
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .set_in  (cor_set),
    .clr_in  (cor_clr),
    .q_out   (cor_status)
  );
  aer_w1c_reg #(.VALID(`AER_SEC_VALID)) u_sec_status ( // R8
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .set_in  (sec_set),
    .clr_in  (sec_clr),
    .q_out   (sec_status)
  );

  // ------------------------------------------------------------
  // Mask, severity, control and interrupt registers
  // ------------------------------------------------------------
  reg  [31:0] unc_mask_q;
  reg  [31:0] unc_mask_d;
  reg  [31:0] unc_sev_q;
  reg  [31:0] unc_sev_d;
  reg  [31:0] cor_mask_q;
  reg  [31:0] cor_mask_d;
  reg         gen_en_d;
  reg         chk_en_d;
  reg  [4:0]  fep_q;
  reg  [4:0]  fep_d;
  reg         fep_valid_q;
  reg         fep_valid_d;
  reg  [2:0]  irq_status_q;
  reg  [2:0]  irq_mask_q;
  reg  [2:0]  irq_mask_d;
  wire [31:0] unc_unmasked;
  wire        first_load;
  reg  [4:0]  first_idx;
  integer     i;

  assign unc_unmasked = unc_set & ~unc_mask_q;
  // Pointer stays locked until software clears the status bit it names
  assign first_load = (|unc_unmasked) & ~fep_valid_q; // R11

  // Lowest set bit wins when several errors arrive together
  always @* begin
    first_idx = 5'h00;
    for (i = 20; i >= 0; i = i - 1) begin
      if (unc_unmasked[i]) begin
        first_idx = i[4:0];
      end
    end
  end

  // Byte lanes apply independently; reserved bits never stick
  always @* begin
    unc_mask_d = unc_mask_q;
    unc_sev_d  = unc_sev_q;
    cor_mask_d = cor_mask_q;
    gen_en_d   = ecrc_gen_en_out;
    chk_en_d   = ecrc_chk_en_out;
    irq_mask_d = irq_mask_q;
    if (wr_unc_mask) begin
      unc_mask_d = merge(unc_mask_q, wb_dat_in, bmask) & `AER_UNC_VALID; // R2
    end
    if (wr_unc_sev) begin
      unc_sev_d = merge(unc_sev_q, wb_dat_in, bmask) & `AER_UNC_VALID; // R3
    end
    if (wr_cor_mask) begin
      cor_mask_d = merge(cor_mask_q, wb_dat_in, bmask) & `AER_COR_VALID; // R5
    end
    if (wr_cap_ctrl && wb_sel_in[0]) begin
      gen_en_d = wb_dat_in[`AER_CAP_GEN_EN]; // R6
    end
    if (wr_cap_ctrl && wb_sel_in[1]) begin
      chk_en_d = wb_dat_in[`AER_CAP_CHK_EN]; // R6
    end
    if (wr_irq_mask && wb_sel_in[0]) begin
      irq_mask_d = wb_dat_in[2:0];
    end
  end

  // No separate sticky reset: nrst_in resets these with everything else, severity to AER_UNC_SEV_RESET
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      unc_mask_q      <= 32'h00000000;
      unc_sev_q       <= `AER_UNC_SEV_RESET;
      cor_mask_q      <= 32'h00000000;
      ecrc_gen_en_out <= 1'b0;
      ecrc_chk_en_out <= 1'b0;
      irq_mask_q      <= 3'h0;
    end else begin
      unc_mask_q      <= unc_mask_d;
      unc_sev_q       <= unc_sev_d;
      cor_mask_q      <= cor_mask_d;
      ecrc_gen_en_out <= gen_en_d;
      ecrc_chk_en_out <= chk_en_d;
      irq_mask_q      <= irq_mask_d;
    end
  end

  // An error arriving in the cycle that unlocks the pointer is not captured
  always @* begin
    fep_d       = fep_q;
    fep_valid_d = fep_valid_q;
    if (first_load) begin
      fep_d       = first_idx; // R11
      fep_valid_d = 1'b1;
    end else if (fep_valid_q && !unc_status[fep_q]) begin
      fep_valid_d = 1'b0;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fep_q       <= 5'h00;
      fep_valid_q <= 1'b0;
    end else begin
      fep_q       <= fep_d;
      fep_valid_q <= fep_valid_d;
    end
  end

  // ------------------------------------------------------------
  // Interrupt: summary events, set wins over clear
  // ------------------------------------------------------------
  wire [2:0] irq_ev;
  wire [2:0] irq_clr;
  wire [2:0] irq_status_d;
  assign irq_ev  = {|sec_set, |(cor_set & ~cor_mask_q), |unc_unmasked}; // R10
  assign irq_clr = (wr_irq_st && wb_sel_in[0]) ? wb_dat_in[2:0] : 3'h0;
  // Line follows the next status, so a clear takes it low on the same edge that raises the ack
  assign irq_status_d = ((irq_status_q & ~irq_clr) | irq_ev) & `AER_IRQ_VALID;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status_q <= 3'h0;
      irq_out      <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_out      <= |(irq_status_d & irq_mask_q);
    end
  end

  // ------------------------------------------------------------
  // Header log
  // ------------------------------------------------------------
  wire [31:0] hdr_rd;
  wire        hdr_sel;
  wire [1:0]  hdr_idx;
  // Only the four log words; the secondary status word shares their address row
  assign hdr_sel = hit(wb_adr_in, `AER_OFS_HDR_LOG0) | hit(wb_adr_in, `AER_OFS_HDR_LOG1) |
                   hit(wb_adr_in, `AER_OFS_HDR_LOG2) | hit(wb_adr_in, `AER_OFS_HDR_LOG3);
  // The first log word sits in the last slot of its row, so the index wraps from 3 to 0
  assign hdr_idx = wb_adr_in[3:2] + 2'b01;
  aer_hdr_log u_hdr_log (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .load_in     (first_load),
    .hdr_in      (unc_hdr_in),
    .rd_idx_in   (hdr_idx),
    .rd_data_out (hdr_rd)
  );

  // ------------------------------------------------------------
  // Read mux and ack: two-cycle answer, data registered
  // ------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (hit(wb_adr_in, `AER_OFS_UNC_STATUS)) begin
      rd_mux = unc_status;
    end else if (hit(wb_adr_in, `AER_OFS_UNC_MASK)) begin
      rd_mux = unc_mask_q;
    end else if (hit(wb_adr_in, `AER_OFS_UNC_SEV)) begin
      rd_mux = unc_sev_q;
    end else if (hit(wb_adr_in, `AER_OFS_COR_STATUS)) begin
      rd_mux = cor_status;
    end else if (hit(wb_adr_in, `AER_OFS_COR_MASK)) begin
      rd_mux = cor_mask_q;
    end else if (hit(wb_adr_in, `AER_OFS_CAP_CTRL)) begin
      rd_mux = cap_word(fep_q, ecrc_gen_en_out, ecrc_chk_en_out); // R6
    end else if (hdr_sel) begin
      rd_mux = hdr_rd; // R7
    end else if (hit(wb_adr_in, `AER_OFS_SEC_STATUS)) begin
      rd_mux = sec_status;
    end else if (hit(wb_adr_in, `AER_OFS_IRQ_STATUS)) begin
      rd_mux[2:0] = irq_status_q;
    end else if (hit(wb_adr_in, `AER_OFS_IRQ_MASK)) begin
      rd_mux[2:0] = irq_mask_q;
    end
  end

  // First cycle lets the header log read register settle
  reg         phase_d;
  reg         ack_d;
  reg  [31:0] dat_d;
  // Unmapped addresses still answer, reading zero, so a stray access never hangs
  always @* begin
    phase_d = 1'b0;
    ack_d   = 1'b0;
    dat_d   = wb_dat_out;
    if (req && !phase_q) begin
      phase_d = 1'b1;
    end else if (req && phase_q) begin
      ack_d = 1'b1;
      dat_d = wb_we_in ? 32'h00000000 : rd_mux;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q    <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      phase_q    <= phase_d;
      wb_ack_out <= ack_d;
      wb_dat_out <= dat_d;
    end
  end
endmodule

// >>> aer_regs_top_tb.sv
// Self-checking bench for the error reporting register bank
module aer_regs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] HDR = 128'h00112233445566778899AABBCCDDEEFF;
  logic clk_in, nrst_in, cyc, stb, we, ack, gen, chk_en, irq;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, unc, cor, sec, r;
  logic [127:0] hdr;
  int bad_count, cmp_count;
  int bl[6] = '{0, 1, 2, 3, 11, 12};
  aer_regs_top i_aer_regs_top (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .unc_err_in(unc), .unc_hdr_in(hdr), .cor_err_in(cor),
    .sec_err_in(sec), .ecrc_gen_en_out(gen), .ecrc_chk_en_out(chk_en), .irq_out(irq));
  aer_err_src i_aer_err_src (.clk_in(clk_in), .unc_err_out(unc), .unc_hdr_out(hdr),
    .cor_err_out(cor), .sec_err_out(sec));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task report_and_stop();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack under a bounded count
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do begin @(posedge clk_in); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; $display("BAD t=%0t no ack", $time); end
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    xfer(a, 1'b1, d, s);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, 4'hF);
    check(r, e);
  endtask
  task irq_is(input logic e);
    repeat (3) @(posedge clk_in);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst_in = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h0; sel = 4'h0; wdat = 32'h0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 11; i++) rd(12'h104 + 12'(4 * i), i == 2 ? 32'h00062011 :
      i == 5 ? 32'h000000A0 : 32'h0);
    for (int i = 1; i < 7; i++) if (i != 3) wr(12'h104 + 12'(4 * i), 32'hFFFFFFFF);
    rd(12'h108, 32'h001FF011);
    rd(12'h10C, 32'h001FF011);
    rd(12'h114, 32'h000011C1);
    rd(12'h118, 32'h000001E0);
    check({30'h0, gen, chk_en}, 32'h3);
    i_aer_err_src.fire(32'hFFFFFFFF, ~HDR, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rd(12'h104, 32'h001FF011);
    rd(12'h110, 32'h000011C1);
    rd(12'h12C, 32'h00003FEF);
    rd(12'h118, 32'h000001E0);
    rd(12'h11C, 32'h0);
    wr(12'h104, 32'hFFFFFFFF, 4'h1);
    rd(12'h104, 32'h001FF000);
    for (int i = 0; i < 11; i += 3) wr(12'h104 + 12'(4 * i), 32'hFFFFFFFF);
    wr(12'h12C, 32'hFFFFFFFF);
    rd(12'h104, 32'h0);
    rd(12'h110, 32'h0);
    rd(12'h12C, 32'h0);
    wr(12'h108, 32'h0);
    i_aer_err_src.fire(32'h00022000, HDR, 32'h0, 32'h0);
    rd(12'h118, 32'h000001ED);
    for (int i = 0; i < 4; i++) rd(12'h11C + 12'(4 * i), HDR[127 - 32 * i -: 32]);
    i_aer_err_src.fire(32'h00000010, ~HDR, 32'h0, 32'h0);
    rd(12'h118, 32'h000001ED);
    rd(12'h11C, HDR[127:96]);
    for (int i = 0; i < 6; i++) begin
      i_aer_err_src.fire(32'h0, HDR, 32'h0, 32'h1 << bl[i]);
      rd(12'h12C, 32'h1 << bl[i]);
      wr(12'h12C, 32'h1 << bl[i]);
    end
    rd(12'h140, 32'h5);
    irq_is(1'b0);
    wr(12'h144, 32'h4);
    irq_is(1'b1);
    wr(12'h140, 32'h4);
    irq_is(1'b0);
    rd(12'h140, 32'h1);
    wr(12'h200, 32'hFFFFFFFF);
    rd(12'h200, 32'h0);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(12'h118, 32'h000000A0);
    rd(12'h10C, 32'h00062011);
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    $display("BAD t=%0t timeout", $time);
    report_and_stop();
  end
endmodule
bind aer_regs_top aer_regs_chk i_aer_regs_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .unc_err_in(unc_err_in),
  .cor_err_in(cor_err_in), .sec_err_in(sec_err_in), .ecrc_gen_en_out(ecrc_gen_en_out),
  .irq_out(irq_out));

// >>> aer_w1c_reg.v
// Sticky write-one-to-clear flag register where a new event wins over the clear
module aer_w1c_reg #(
  parameter [31:0] VALID = 32'h00000000
) (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire [31:0] set_in,
  input  wire [31:0] clr_in,
  output wire [31:0] q_out
);
  reg [31:0] q_q;
  wire [31:0] q_d;
  assign q_d = ((q_q & ~clr_in) | set_in) & VALID;
  assign q_out = q_q;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_q <= 32'h00000000;
    end else begin
      q_q <= q_d;
    end
  end
endmodule
